/* inc/pwsd_pkg.sv */
// Package for the PWM shutdown, dead-band and steering output stage
package pwsd_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] REG_SHUTDOWN = 2'h0;
  localparam logic [1:0] REG_DEADBAND = 2'h1;
  localparam logic [1:0] REG_STEERING = 2'h2;
  localparam logic [1:0] REG_MODE = 2'h3;

  // Reset values
  localparam logic [7:0] SHUTDOWN_RST = 8'h00;
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic [7:0] STEERING_RST = 8'h01;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Field positions
  localparam int FLAG_BIT = 7;
  localparam int SRC_LSB = 4;
  localparam int AC_LSB = 2;
  localparam int BD_LSB = 0;
  localparam int RESTART_BIT = 7;
  localparam int SYNC_BIT = 4;
  localparam int COMPL_PAIR_SEL_LSB = 6;

  // Source select codes and bits
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam int SRC_CMP1_BIT = 0;
  localparam int SRC_CMP2_BIT = 1;
  localparam int SRC_FAULT_BIT = 2;

  // Safe-state encodings
  localparam logic [1:0] SAFE_LOW = 2'h0;
  localparam logic [1:0] SAFE_HIGH = 2'h1;

  // Mode codes
  localparam logic [1:0] CCP_PWM_UPPER = 2'h3;
  localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
  localparam logic [1:0] BRIDGE_HALF = 2'h2;

  // One instruction cycle is this many system clocks
  localparam int CLK_PER_INSTR = 4;

  typedef struct packed {
    logic cmp1_out;
    logic cmp2_out;
    logic fault_in;
  } pwsd_src_t;

  typedef struct packed {
    logic [3:0] drv;
    logic [3:0] oe;
  } pwsd_pins_t;

endpackage

/* verilog/pwsd_top.sv */
// PWM output stage: auto-shutdown, restart, dead-band, pulse steering
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Three source-select bits pick shutdown triggers; zero disables, seven enables all.
// - With fault source selected, a low fault input is a shutdown event.
// - A shutdown event sets the flag in bit 7; one means outputs shut down.
// - Software writing one to the flag creates a shutdown event.
// - Shutdown forces enabled pins to safe states at once, without a clock.
// - A/C pair safe state: 00 low, 01 high, 1x high impedance.
// - B/D pair safe state uses the same encoding.
// - Shutdown persists while any selected source stays asserted.
// - Flag writes are ignored while a selected condition is present.
// - After the flag clears, output resumes at the next period start.
// - Restart enable bit 7 lets hardware clear the flag once condition goes.
// - With auto restart, flag stays set throughout the active condition.
// - Half-bridge dead-band delays only inactive-to-active edges.
// - Seven-bit delay count in instruction cycles of four system clocks.
// - Steering is active only in PWM mode 11 with single output 00.
// - Steering enables D..A route PWM to pins; clear returns pin to port.
// - In steering mode mode bit 0 alone sets polarity of steered pins.
// - In steering mode shutdown forces only steered pins.
// - Sync bit 4 applies steering at next period, else at instruction boundary.
// - Complementary field: 00 uses enables, 01/10/11 pair A with B/C/D.
// - Half-bridge: pin A carries PWM, pin B its complement, both delayed.
// - Dead-band longer than the active time keeps that output inactive.
module pwsd_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Waveform from the duty generator and period start pulse
  input wire logic PWM_RAW,
  input wire logic PERIOD_START,
  // General port data for pins not under PWM control
  input wire logic [3:0] PORT_DATA,
  // Shutdown sources, asynchronous
  input wire pwsd_pkg::pwsd_src_t SRC_IN,
  // Output pins, order D..A
  output pwsd_pkg::pwsd_pins_t PINS,
  output logic SHUTDOWN_ACTIVE
);
  import pwsd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic flag;
    logic [2:0] src_sel;
    logic [1:0] ac_safe;
    logic [1:0] bd_safe;
    logic restart_en;
    logic [6:0] db_count;
    logic [1:0] compl_pair_sel_sel;
    logic sync_sel;
    logic [3:0] steer_req;
    logic [3:0] steer_act;
    logic [3:0] ccp_mode;
    logic [1:0] bridge_mode;
    logic hold;
    logic [1:0] q_cnt;
    logic [6:0] db_a;
    logic [6:0] db_b;
    logic pwm_d;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [7:0] rdata;
    logic [3:0] pin_ff;
  } pwsd_state_t;

  localparam pwsd_state_t STATE_RST = '{
    flag: SHUTDOWN_RST[FLAG_BIT],
    src_sel: SHUTDOWN_RST[SRC_LSB +: 3],
    ac_safe: SHUTDOWN_RST[AC_LSB +: 2],
    bd_safe: SHUTDOWN_RST[BD_LSB +: 2],
    restart_en: DEADBAND_RST[RESTART_BIT],
    db_count: DEADBAND_RST[6:0],
    compl_pair_sel_sel: STEERING_RST[COMPL_PAIR_SEL_LSB +: 2],
    sync_sel: STEERING_RST[SYNC_BIT],
    steer_req: STEERING_RST[3:0],
    steer_act: STEERING_RST[3:0],
    ccp_mode: MODE_RST[3:0],
    bridge_mode: MODE_RST[7:6],
    hold: 1'b0,
    q_cnt: 2'h0,
    db_a: 7'h00,
    db_b: 7'h00,
    pwm_d: 1'b0,
    sync1: 3'h0,
    sync2: 3'h0,
    rdata: 8'h00,
    pin_ff: 4'h0
  };

  pwsd_state_t st_ff;
  pwsd_state_t nxt_st;

  //////////////////////////////////////////////////////////////////////////////
  // Shutdown request
  logic [2:0] raw_src;
  logic cond_async;
  logic cond_sync;
  logic sw_set;
  logic shut_now;
  logic instr_tick;
  logic steer_mode;
  logic half_mode;
  logic [3:0] pwm_route;
  logic [3:0] shut_mask;
  logic [3:0] pin_oe;
  logic [3:0] pin_drv;
  logic [3:0] safe_oe;
  logic [3:0] safe_lvl;

  // Source bits ordered as the select bits
  assign raw_src = {~SRC_IN.fault_in, SRC_IN.cmp2_out, SRC_IN.cmp1_out};
  assign cond_async = |(raw_src & st_ff.src_sel);
  assign cond_sync = |(st_ff.sync2 & st_ff.src_sel);
  assign sw_set = REG_WR && (REG_ADDR == REG_SHUTDOWN) && REG_WDATA[FLAG_BIT];
  // Unclocked path so the pins react before the next edge
  assign shut_now = st_ff.flag || cond_async;
  assign instr_tick = (st_ff.q_cnt == 2'(CLK_PER_INSTR - 1));
  assign steer_mode = (st_ff.ccp_mode[3:2] == CCP_PWM_UPPER) &&
                      (st_ff.bridge_mode == BRIDGE_SINGLE);
  assign half_mode = (st_ff.bridge_mode == BRIDGE_HALF);

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = raw_src;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.q_cnt = st_ff.q_cnt + 2'h1;
    nxt_st.pwm_d = PWM_RAW;
    nxt_st.rdata = 8'h00;
    // Port and PWM levels reach the pins through this register
    nxt_st.pin_ff = pwm_route;
    if (REG_WR) begin
      unique case (REG_ADDR)
        REG_SHUTDOWN: begin
          nxt_st.src_sel = REG_WDATA[SRC_LSB +: 3];
          nxt_st.ac_safe = REG_WDATA[AC_LSB +: 2];
          nxt_st.bd_safe = REG_WDATA[BD_LSB +: 2];
          if (!cond_sync) begin
            nxt_st.flag = REG_WDATA[FLAG_BIT];
          end
        end
        REG_DEADBAND: begin
          nxt_st.restart_en = REG_WDATA[RESTART_BIT];
          nxt_st.db_count = REG_WDATA[6:0];
        end
        REG_STEERING: begin
          nxt_st.compl_pair_sel_sel = REG_WDATA[COMPL_PAIR_SEL_LSB +: 2];
          nxt_st.sync_sel = REG_WDATA[SYNC_BIT];
          nxt_st.steer_req = REG_WDATA[3:0];
        end
        REG_MODE: begin
          nxt_st.bridge_mode = REG_WDATA[7:6];
          nxt_st.ccp_mode = REG_WDATA[3:0];
        end
      endcase
    end
    // Hardware set wins over any clear
    if (cond_sync) begin
      nxt_st.flag = 1'b1;
    end else if (st_ff.restart_en && st_ff.flag && !sw_set) begin
      nxt_st.flag = 1'b0;
    end
    // Outputs stay parked until the next period once the flag drops
    // Only synchronised sources reach this register
    if (st_ff.flag || cond_sync) begin
      nxt_st.hold = 1'b1;
    end else if (PERIOD_START) begin
      nxt_st.hold = 1'b0;
    end
    // Steering update timing
    if (st_ff.sync_sel) begin
      if (PERIOD_START) begin
        nxt_st.steer_act = st_ff.steer_req;
      end
    end else if (instr_tick) begin
      nxt_st.steer_act = st_ff.steer_req;
    end
    // Dead-band counters run on instruction ticks; A clears while PWM is low, B while high
    if (!PWM_RAW) begin
      nxt_st.db_a = 7'h00;
    end else if (instr_tick && st_ff.db_a != st_ff.db_count) begin
      nxt_st.db_a = st_ff.db_a + 7'h01;
    end
    if (PWM_RAW) begin
      nxt_st.db_b = 7'h00;
    end else if (instr_tick && st_ff.db_b != st_ff.db_count) begin
      nxt_st.db_b = st_ff.db_b + 7'h01;
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_SHUTDOWN: nxt_st.rdata = {st_ff.flag, st_ff.src_sel, st_ff.ac_safe, st_ff.bd_safe};
        REG_DEADBAND: nxt_st.rdata = {st_ff.restart_en, st_ff.db_count};
        REG_STEERING: nxt_st.rdata = {st_ff.compl_pair_sel_sel, 1'b0, st_ff.sync_sel, st_ff.steer_req};
        REG_MODE: nxt_st.rdata = {st_ff.bridge_mode, 2'h0, st_ff.ccp_mode};
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Waveform routing
  logic pwm_a;
  logic pwm_b;
  logic pwm_pol;
  always_comb begin
    // Active edge waits for the count; inactive edge passes at once
    pwm_a = PWM_RAW && (st_ff.db_a == st_ff.db_count);
    pwm_b = !PWM_RAW && (st_ff.db_b == st_ff.db_count);
    pwm_pol = PWM_RAW ^ st_ff.ccp_mode[0];
    pwm_route = PORT_DATA;
    pin_oe = 4'h0;
    if (half_mode) begin
      pwm_route = {PORT_DATA[3:2], pwm_b, pwm_a};
      pin_oe = 4'h3;
    end else if (steer_mode) begin
      unique case (st_ff.compl_pair_sel_sel)
        2'h0: begin
          pin_oe = st_ff.steer_act;
          pwm_route = (st_ff.steer_act & {4{pwm_pol}}) | (~st_ff.steer_act & PORT_DATA);
        end
        2'h1: begin
          pin_oe = 4'h3;
          pwm_route = {PORT_DATA[3:2], ~pwm_pol, pwm_pol};
        end
        2'h2: begin
          pin_oe = 4'h5;
          pwm_route = {PORT_DATA[3], ~pwm_pol, PORT_DATA[1], pwm_pol};
        end
        2'h3: begin
          pin_oe = 4'h9;
          pwm_route = {~pwm_pol, PORT_DATA[2:1], pwm_pol};
        end
      endcase
    end
  end

  // Safe levels per pair, order D C B A
  assign safe_oe = {~st_ff.bd_safe[1], ~st_ff.ac_safe[1],
                    ~st_ff.bd_safe[1], ~st_ff.ac_safe[1]};
  assign safe_lvl = {st_ff.bd_safe == SAFE_HIGH, st_ff.ac_safe == SAFE_HIGH,
                     st_ff.bd_safe == SAFE_HIGH, st_ff.ac_safe == SAFE_HIGH};
  // Only PWM-owned pins are forced
  assign shut_mask = pin_oe;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (shut_mask[i] && shut_now) begin
        pin_drv[i] = safe_lvl[i];
      end else if (shut_mask[i] && st_ff.hold) begin
        pin_drv[i] = safe_lvl[i];
      end else begin
        pin_drv[i] = st_ff.pin_ff[i];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PINS.drv = pin_drv;
  assign PINS.oe = (shut_now || st_ff.hold) ? ((shut_mask & safe_oe) | ~shut_mask) : 4'hf;
  assign REG_RDATA = st_ff.rdata;
  assign SHUTDOWN_ACTIVE = st_ff.flag;
endmodule

/* verification/pwsd_srcm.sv */
// Model of the fault pin and the two comparator outputs
module pwsd_srcm (
  // Source levels toward the block
  output pwsd_pkg::pwsd_src_t src
);
  timeunit 1ns;
  timeprecision 100ps;
  import pwsd_pkg::*;
  initial src = '{cmp1_out: 1'b0, cmp2_out: 1'b0, fault_in: 1'b1};
  // Levels move a little after the caller's clock edge, unrelated to the block
  task automatic drive(input logic c1, c2, flt);
    #3 src = '{cmp1_out: c1, cmp2_out: c2, fault_in: flt};
  endtask
endmodule

/* verification/pwsd_sva.sv */
// Assertion checker for the PWM output stage ports
module pwsd_sva (
  // Clock, reset and register port
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Period, sources and pins
  input wire logic PERIOD_START,
  input wire pwsd_pkg::pwsd_src_t SRC_IN,
  input wire pwsd_pkg::pwsd_pins_t PINS,
  input wire logic SHUTDOWN_ACTIVE
);
  import pwsd_pkg::*;
  logic [7:0] sd_ff, st_ff, mo_ff;
  logic rs_ff;
  logic req, own, w0;
  assign w0 = REG_WR && REG_ADDR == REG_SHUTDOWN;
  assign req = |(sd_ff[6:4] & {!SRC_IN.fault_in, SRC_IN.cmp2_out, SRC_IN.cmp1_out});
  // Pin A belongs to the PWM in half-bridge or when steered in single mode
  assign own = mo_ff[3:2] == CCP_PWM_UPPER &&
    (mo_ff[7:6] == BRIDGE_HALF || mo_ff[7:6] == BRIDGE_SINGLE && st_ff[0]);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sd_ff <= 8'h00;
      st_ff <= 8'h01;
      mo_ff <= 8'h00;
      rs_ff <= 1'b0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        REG_SHUTDOWN: sd_ff <= REG_WDATA;
        REG_DEADBAND: rs_ff <= REG_WDATA[RESTART_BIT];
        REG_STEERING: st_ff <= REG_WDATA;
        default: mo_ff <= REG_WDATA;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence held_req;
    req [*5];
  endsequence
  sequence flag_clr_wr;
    w0 && !REG_WDATA[FLAG_BIT];
  endsequence
  rd_idle_a: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data not zero outside read cycle");
  sw_set_a: assert property (w0 && REG_WDATA[FLAG_BIT] |-> ##[1:3] SHUTDOWN_ACTIVE)
    else $error("software set did not shut down");
  src_flag_a: assert property (req [*3] |-> ##[0:3] SHUTDOWN_ACTIVE)
    else $error("selected source did not set flag");
  flag_hold_a: assert property (req && SHUTDOWN_ACTIVE |=> SHUTDOWN_ACTIVE)
    else $error("flag dropped while source active");
  wr_ignore_a: assert property (held_req ##0 flag_clr_wr |=> SHUTDOWN_ACTIVE)
    else $error("flag clear accepted during shutdown");
  safe_pin_a: assert property (req && own |->
    (sd_ff[3] ? !PINS.oe[0] : PINS.oe[0] && PINS.drv[0] == sd_ff[2]))
    else $error("pin A not in safe state");
  resume_a: assert property ($fell(SHUTDOWN_ACTIVE) && !PERIOD_START && own &&
    sd_ff[3:2] == SAFE_HIGH |-> PINS.drv[0])
    else $error("output resumed before period start");
  restart_a: assert property ((rs_ff && !req && !REG_WR) [*6] |-> !SHUTDOWN_ACTIVE)
    else $error("auto restart did not clear flag");
endmodule
bind pwsd_top pwsd_sva pwsd_sva_inst (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .PERIOD_START(PERIOD_START), .SRC_IN(SRC_IN), .PINS(PINS),
  .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE));

/* verification/test_pwsd_top.sv */
// Self-checking bench for the PWM output stage
module test_pwsd_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pwsd_pkg::*;
  `define CHK(a, e) begin \
    n_tests++; \
    if ((a) !== (e)) begin \
      err_count++; \
      $display("wrong value at %0t: %h expected %h", $time, a, e); \
    end \
  end
  logic clk, rst_n, wr, rd, pwm, per;
  logic [1:0] addr;
  logic [7:0] wd, rdat;
  logic [3:0] port;
  pwsd_src_t src;
  pwsd_pins_t pins;
  logic sd;
  int err_count, n_tests, cnt;
  pwsd_top pwsd_top_inst (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .PWM_RAW(pwm), .PERIOD_START(per),
    .PORT_DATA(port), .SRC_IN(src), .PINS(pins), .SHUTDOWN_ACTIVE(sd));
  pwsd_srcm pwsd_srcm_inst (.src(src));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cnt++;
    if (cnt == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  // Ends on a falling edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdat, e)
  endtask
  task automatic pulse;
    @(posedge clk);
    per <= 1'b1;
    @(posedge clk);
    per <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_steer;
    wreg(REG_MODE, 8'h0c);
    wreg(REG_STEERING, 8'h05);
    pwm <= 1'b1;
    port <= 4'ha;
    cyc(8);
    `CHK(pins.drv, 4'hf)
    port <= 4'h0;
    cyc(2);
    `CHK(pins.drv, 4'h5)
    wreg(REG_STEERING, 8'h11);
    cyc(8);
    `CHK(pins.drv, 4'h5)
    pulse();
    cyc(3);
    `CHK(pins.drv, 4'h1)
  endtask
  task automatic t_fault;
    pwm <= 1'b0;
    wreg(REG_SHUTDOWN, 8'h44);
    cyc(1);
    pwsd_srcm_inst.drive(1'b0, 1'b0, 1'b0);
    #1 `CHK(pins.drv[2:0], 3'h1)
    cyc(6);
    rchk(REG_SHUTDOWN, 8'hc4);
    wreg(REG_SHUTDOWN, 8'h44);
    rchk(REG_SHUTDOWN, 8'hc4);
    pwsd_srcm_inst.drive(1'b0, 1'b0, 1'b1);
    cyc(8);
    rchk(REG_SHUTDOWN, 8'hc4);
    wreg(REG_SHUTDOWN, 8'h44);
    cyc(4);
    `CHK({sd, pins.drv[0]}, 2'b01)
    pulse();
    cyc(3);
    `CHK(pins.drv[0], 1'b0)
  endtask
  task automatic t_swset;
    pwm <= 1'b1;
    wreg(REG_SHUTDOWN, 8'h80);
    cyc(3);
    `CHK({sd, pins.drv[0]}, 2'b10)
    wreg(REG_SHUTDOWN, 8'h00);
    pulse();
    pwsd_srcm_inst.drive(1'b1, 1'b1, 1'b0);
    cyc(6);
    `CHK(sd, 1'b0)
    pwsd_srcm_inst.drive(1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_restart;
    wreg(REG_DEADBAND, 8'h80);
    wreg(REG_SHUTDOWN, 8'h18);
    cyc(1);
    pwsd_srcm_inst.drive(1'b1, 1'b0, 1'b1);
    #1 `CHK(pins.oe[0], 1'b0)
    cyc(6);
    `CHK(sd, 1'b1)
    pwsd_srcm_inst.drive(1'b0, 1'b0, 1'b1);
    cyc(6);
    `CHK(sd, 1'b0)
  endtask
  task automatic t_dead;
    pwm <= 1'b0;
    wreg(REG_MODE, 8'h8c);
    wreg(REG_DEADBAND, 8'h03);
    pulse();
    cyc(20);
    `CHK(pins.drv[1:0], 2'b10)
    pwm <= 1'b1;
    cyc(8);
    `CHK(pins.drv[1:0], 2'b00)
    cyc(9);
    `CHK(pins.drv[1:0], 2'b01)
    pwm <= 1'b0;
    cyc(2);
    `CHK(pins.drv[1:0], 2'b00)
  endtask
  initial begin
    {rst_n, wr, rd, pwm, per, addr, wd, port, err_count, n_tests, cnt} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(REG_SHUTDOWN, 8'h00);
    rchk(REG_DEADBAND, 8'h00);
    rchk(REG_STEERING, 8'h01);
    t_steer();
    t_fault();
    t_swset();
    t_restart();
    t_dead();
    wrap_up();
  end
endmodule
